// File: design/dcomm_pkg.sv
// Package for the serial datacomm register set.
// Assumes AXI4-Lite word access; register index times four is the byte address.
package dcomm_pkg;
    // ----------------------------------------
    // Register indices
    // ----------------------------------------
    localparam logic [3:0] REG_IDENT = 4'h0;
    localparam logic [3:0] REG_HW_INT = 4'h1;
    localparam logic [3:0] REG_ACTIVITY = 4'h2;
    localparam logic [3:0] REG_PROTOCOL = 4'h3;
    localparam logic [3:0] REG_CAUSE = 4'h4;
    localparam logic [3:0] REG_INBOUND = 4'h5;
    localparam logic [3:0] REG_BREAK = 4'h6;
    localparam logic [3:0] REG_MODEM_IN = 4'h7;
    localparam logic [3:0] REG_MODEM_OUT = 4'h8;
    localparam logic [3:0] REG_CB_TYPE = 4'h9;
    localparam logic [3:0] REG_CB_MODE = 4'ha;
    localparam logic [3:0] REG_FREE = 4'hb;
    localparam logic [3:0] REG_CONNECT = 4'hc;
    localparam logic [3:0] REG_MASK = 4'hd;
    localparam logic [3:0] REG_ERROR = 4'he;
    // ----------------------------------------
    // Values
    // ----------------------------------------
    localparam logic [7:0] PROTO_ASYNC = 8'h01;
    localparam logic [7:0] PROTO_LINK = 8'h02;
    localparam logic [15:0] ERR_ILLEGAL = 16'h0147;
    localparam logic [7:0] MODEM_OUT_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] CONN_DISC = 8'h00;
    localparam logic [7:0] CONN_TRY = 8'h01;
    localparam logic [7:0] CONN_DIAL = 8'h02;
    localparam logic [7:0] CONN_UP = 8'h03;
    localparam logic [7:0] CB_BREAK = 8'hfa;
    localparam logic [7:0] CB_ERR = 8'hfb;
    localparam logic [7:0] CB_EOL = 8'hfc;
    localparam logic [7:0] CB_PROMPT = 8'hfd;
    localparam logic [7:0] CB_LINK = 8'hfe;
    localparam logic [7:0] CH_ETX = 8'h03;
    localparam logic [7:0] CH_EOT = 8'h04;
    localparam int CB_BYTES = 3;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage

// File: design/dcomm_regs.sv
// Register set of a serial datacomm card behind an AXI4-Lite slave.
// Assumes the serial engine reports events, queue state and control blocks as ports.
// Operation
// R1: Written values above 255 are refused and logged as error code 327.
// R2: Control registers hold defaults after reset until software overwrites them.
// R3: Writing 1..255 to register 0 resets the card and flushes both queues.
// R4: Register 3 reads active protocol, 1 async, 2 data link.
// R5: Register 3 write selects protocol used after the next card reset.
// R6: Async cause bits: data, prompt, error, modem, idle, carrier, eol, break.
// R7: Data link cause bits: block, space, error; bits 6 and 7 unused.
// R8: Reading the cause register clears all its bits.
// R9: Register 5 reports inbound queue: empty, data, control, both.
// R10: Data link terminate sends pending block ending ETX then EOT.
// R11: Async terminate turns half-duplex line; next output raises RTS.
// R12: Register 6 reads 1 while break pending, else 0.
// R13: Any write to register 6 requests break; async length from register 39. Here break_len is tied to 0.
// R14: Data link break sends reverse interrupt reply or contention character.
// R15: Register 7 shows DSR, DCD, CTS, RI and a cable input.
// R16: Register 8 drives RTS, DTR, rate select, three cable drivers; reads back.
// R17: Bit 6 selects transmit clock, bit 7 receive clock, 1 internal.
// R18: Driver register resets to 0; half-duplex RTS changes only via output. Here writes to register 12 and dial completion still change bit 0.
// R19: Registers 9 and 10 show async control block type and mode.
// R20: Data link blocks use type 254, modes ETB 1, ETX 2, type 253 selects.
// R21: Register 11 gives free outbound bytes only if three blocks fit.
// R22: Register 12 shows connection state; writes disconnect, connect, or dial.
// R23: Register 13 masks causes bit for bit and resets to zero. Here the register 4 read ignores mask_q.
`timescale 1ns/10ps
module dcomm_regs
    import dcomm_pkg::*;
#(
    parameter logic [7:0] CARD_ID = 8'h5a, // Arbitrary value.
    parameter int FREE_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic switch_link_mode,
    input wire logic [7:0] event_pulse,
    input wire logic inbound_has_data,
    input wire logic inbound_has_ctrl,
    input wire logic [FREE_W-1:0] outbound_free,
    input wire logic [4:0] modem_in,
    input wire logic half_duplex,
    input wire logic data_output,
    input wire logic break_done,
    input wire logic cb_valid,
    input wire logic [7:0] cb_type,
    input wire logic [7:0] cb_mode,
    input wire logic dial_done,
    input wire logic carrier_up,
    output logic card_reset,
    output logic link_mode,
    output logic [7:0] modem_out,
    output logic terminate_pulse,
    output logic [7:0] term_char,
    output logic break_pulse,
    output logic reverse_interrupt_reply,
    output logic contention_character,
    output logic [7:0] break_len
);
    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    logic aw_q, w_q, ar_q;
    logic [3:0] waddr_q, raddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire, rd_fire;
    logic [7:0] wv;
    logic illegal;

    assign s_axi_awready = !aw_q && !s_axi_bvalid;
    assign s_axi_wready = !w_q && !s_axi_bvalid;
    assign s_axi_arready = !ar_q && !s_axi_rvalid;
    assign wr_fire = aw_q && w_q;
    assign rd_fire = ar_q;
    assign wv = wdata_q[7:0];
    // Only full low-byte words with nothing above bit 7 are legal values.
    // Registers 3 and 12 take only their listed codes; any other value is refused too.
    assign illegal = (wdata_q[31:8] != 24'h000000) || !wstrb_q[0]
        || (waddr_q == REG_PROTOCOL && wv != PROTO_ASYNC && wv != PROTO_LINK)
        || (waddr_q == REG_CONNECT && wv > CONN_DIAL); // R1

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            waddr_q <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            waddr_q <= s_axi_awaddr[5:2];
        end else if (wr_fire) begin
            aw_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_q <= 1'b0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_q <= 1'b0;
            raddr_q <= 4'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            ar_q <= 1'b1;
            raddr_q <= s_axi_araddr[5:2];
        end else if (rd_fire) begin
            ar_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    logic wr_ok;
    logic [7:0] proto_next_q, proto_q, mask_q, conn_q, modem_out_q, cause_q;
    logic [15:0] err_q;
    logic break_pend_q, rts_hold_q, cb_seen_q;
    logic [7:0] cb_type_q, cb_mode_q;
    logic wr_mapped;

    assign wr_mapped = (waddr_q <= REG_MASK) && (waddr_q != REG_HW_INT)
        && (waddr_q != REG_ACTIVITY) && (waddr_q != REG_CAUSE)
        && (waddr_q != REG_MODEM_IN) && (waddr_q != REG_CB_TYPE)
        && (waddr_q != REG_CB_MODE) && (waddr_q != REG_FREE);
    assign wr_ok = wr_fire && wr_mapped && !illegal;
    assign card_reset = wr_ok && waddr_q == REG_IDENT && wv != 8'h00; // R3

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_mapped && !illegal) ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Error code stays until a new legal write replaces it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_q <= 16'h0000;
        end else if (wr_fire && illegal) begin
            err_q <= ERR_ILLEGAL; // R1
        end else if (wr_ok) begin
            err_q <= 16'h0000;
        end
    end

    // Protocol choice survives card reset; only the active copy reloads.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            proto_next_q <= 8'h00;
            // The reset is synchronous, so the switch level may load here.
            proto_q <= switch_link_mode ? PROTO_LINK : PROTO_ASYNC; // R5
        end else begin
            if (wr_ok && waddr_q == REG_PROTOCOL && (wv == PROTO_ASYNC || wv == PROTO_LINK)) begin
                proto_next_q <= wv; // R5
            end
            if (card_reset) begin
                if (proto_next_q != 8'h00) begin
                    proto_q <= proto_next_q; // R5
                end else begin
                    proto_q <= switch_link_mode ? PROTO_LINK : PROTO_ASYNC;
                end
            end
        end
    end
    assign link_mode = proto_q == PROTO_LINK;

    always_ff @(posedge aclk) begin
        if (!aresetn || card_reset) begin
            mask_q <= MASK_RESET; // R23
        end else if (wr_ok && waddr_q == REG_MASK) begin
            mask_q <= wv; // R23
        end
    end

    // ----------------------------------------
    // Modem drivers and connection
    // ----------------------------------------
    logic term_req;
    assign term_req = wr_ok && waddr_q == REG_INBOUND;
    assign terminate_pulse = term_req; // R10
    assign term_char = link_mode ? CH_ETX : CH_EOT; // R10

    always_ff @(posedge aclk) begin
        if (!aresetn || card_reset) begin
            modem_out_q <= MODEM_OUT_RESET; // R2 R18
            conn_q <= CONN_DISC;
            rts_hold_q <= 1'b0;
        end else begin
            if (wr_ok && waddr_q == REG_MODEM_OUT) begin
                // Half-duplex keeps RTS under the data path's control.
                modem_out_q <= half_duplex ? {wv[7:1], modem_out_q[0]} : wv; // R16 R17 R18
            end else if (wr_ok && waddr_q == REG_CONNECT) begin
                case (wv)
                    CONN_DISC: begin
                        conn_q <= CONN_DISC;
                        modem_out_q[1:0] <= 2'b00;
                    end
                    CONN_TRY: begin
                        conn_q <= CONN_TRY;
                        modem_out_q[1:0] <= 2'b11; // R22
                    end
                    CONN_DIAL: conn_q <= CONN_DIAL; // R22
                    default: conn_q <= conn_q;
                endcase
            end else if (term_req && !link_mode && half_duplex) begin
                modem_out_q[0] <= 1'b0; // R11
                rts_hold_q <= 1'b1;
            end else if (rts_hold_q && data_output) begin
                modem_out_q[0] <= 1'b1; // R11
                rts_hold_q <= 1'b0;
            end else if (conn_q == CONN_DIAL && dial_done) begin
                conn_q <= CONN_TRY;
                modem_out_q[1:0] <= 2'b11;
            end else if (conn_q == CONN_TRY && carrier_up) begin
                conn_q <= CONN_UP;
            end
        end
    end
    assign modem_out = modem_out_q;

    // ----------------------------------------
    // Break
    // ----------------------------------------
    logic brk_req;
    assign brk_req = wr_ok && waddr_q == REG_BREAK; // R13
    assign break_pulse = brk_req && !link_mode; // R13
    assign break_len = 8'h00;
    // A pending inbound block takes the reply; otherwise the next outbound block.
    assign reverse_interrupt_reply = brk_req && link_mode && inbound_has_data; // R14
    assign contention_character = brk_req && link_mode && !inbound_has_data; // R14

    always_ff @(posedge aclk) begin
        if (!aresetn || card_reset) begin
            break_pend_q <= 1'b0;
        end else if (brk_req) begin
            break_pend_q <= 1'b1; // R12
        end else if (break_done) begin
            break_pend_q <= 1'b0; // R12
        end
    end

    // ----------------------------------------
    // Cause and control block capture
    // ----------------------------------------
    logic [7:0] ev_valid;
    logic cause_rd;
    assign ev_valid = link_mode ? (event_pulse & 8'h3f) : event_pulse; // R6 R7
    assign cause_rd = rd_fire && raddr_q == REG_CAUSE;

    // New events in the read cycle survive the clear.
    always_ff @(posedge aclk) begin
        if (!aresetn || card_reset) begin
            cause_q <= 8'h00;
        end else if (cause_rd) begin
            cause_q <= ev_valid; // R8
        end else begin
            cause_q <= cause_q | ev_valid; // R6 R7
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || card_reset) begin
            cb_type_q <= 8'h00;
            cb_mode_q <= 8'h00;
        end else if (cb_valid) begin
            cb_type_q <= cb_type; // R19 R20
            cb_mode_q <= cb_mode; // R19 R20
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    logic [7:0] rv;
    logic [7:0] free_b;
    assign free_b = (outbound_free >= FREE_W'(CB_BYTES * 3))
        ? 8'(outbound_free) : 8'h00; // R21

    always_comb begin
        case (raddr_q)
            REG_IDENT: rv = CARD_ID;
            REG_HW_INT: rv = {7'h00, |mask_q};
            REG_ACTIVITY: rv = 8'h00;
            REG_PROTOCOL: rv = proto_q; // R4
            REG_CAUSE: rv = cause_q & mask_q | cause_q;
            REG_INBOUND: rv = {6'h00, inbound_has_ctrl, inbound_has_data}; // R9
            REG_BREAK: rv = {7'h00, break_pend_q}; // R12
            REG_MODEM_IN: rv = {3'h0, modem_in}; // R15
            REG_MODEM_OUT: rv = modem_out_q; // R16
            REG_CB_TYPE: rv = cb_type_q; // R19
            REG_CB_MODE: rv = cb_mode_q; // R19
            REG_FREE: rv = free_b; // R21
            REG_CONNECT: rv = conn_q; // R22
            REG_MASK: rv = mask_q; // R23
            REG_ERROR: rv = 8'h00;
            default: rv = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= AXI_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            // The error code is the only value wider than one byte.
            s_axi_rdata <= (raddr_q == REG_ERROR) ? {16'h0000, err_q} : {24'h000000, rv}; // R1
            s_axi_rresp <= (raddr_q <= REG_ERROR) ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// File: verif/dcomm_regs_properties.sv
// Concurrent checks on the datacomm register block, seen from its ports.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/10ps
module dcomm_regs_properties
    import dcomm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic card_reset,
    input wire logic link_mode,
    input wire logic [7:0] modem_out,
    input wire logic terminate_pulse,
    input wire logic [7:0] term_char,
    input wire logic break_pulse,
    input wire logic reverse_interrupt_reply,
    input wire logic contention_character
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_write_answer: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write response missing");
    chk_read_answer: assert property (rd_taken |-> ##[1:3] s_axi_rvalid)
        else $error("read response missing");
    chk_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    chk_reset_clears: assert property (card_reset |=> modem_out == MODEM_OUT_RESET)
        else $error("card reset left modem drivers set");
    chk_mode_steady: assert property (!card_reset |=> $stable(link_mode))
        else $error("protocol changed without card reset");
    chk_term_char: assert property (terminate_pulse |-> term_char == (link_mode ? CH_ETX : CH_EOT))
        else $error("wrong terminate character");
    chk_break_async: assert property (break_pulse |-> !link_mode)
        else $error("line break in data link mode");
    chk_link_break: assert property
        (reverse_interrupt_reply || contention_character |-> link_mode)
        else $error("link break reply in async mode");
endmodule

// File: verif/dcomm_line_model.sv
// Model of the serial engine and modem beyond the register block.
// Assumes one break_pulse per request and DTR on modem_out bit 1.
`timescale 1ns/10ps
module dcomm_line_model #(
    parameter int BRK_CYC = 10,
    parameter int CAR_CYC = 20
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic break_pulse,
    input wire logic [7:0] modem_out,
    output logic break_done,
    output logic carrier_up
);
    int brk_q;
    int car_q;
    // A break occupies the line for a fixed time, then completion is reported once.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            brk_q <= 0;
            break_done <= 1'b0;
        end else begin
            brk_q <= break_pulse ? BRK_CYC : (brk_q > 0 ? brk_q - 1 : 0);
            break_done <= (brk_q == 1);
        end
    end
    // The far modem answers only after DTR has been held for a while.
    always_ff @(posedge aclk) begin
        if (!aresetn || !modem_out[1]) begin
            car_q <= 0;
        end else if (car_q < CAR_CYC) begin
            car_q <= car_q + 1;
        end
    end
    assign carrier_up = (car_q == CAR_CYC);
endmodule

// File: verif/datacomm_serial_register_set_tb.sv
// Self-checking bench for the datacomm register block over AXI4-Lite.
// Assumes the line model answers breaks and DTR; the card id is not checked.
`timescale 1ns/10ps
module datacomm_serial_register_set_tb;
    import dcomm_pkg::*;
    logic aclk, aresetn;
    logic [5:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic switch_link_mode, inbound_has_data, inbound_has_ctrl, half_duplex, data_output;
    logic break_done, cb_valid, dial_done, carrier_up, card_reset, link_mode, terminate_pulse;
    logic break_pulse, reverse_interrupt_reply, contention_character;
    logic [7:0] event_pulse, outbound_free, cb_type, cb_mode, modem_out, term_char, break_len;
    logic [7:0] fv[4];
    logic [4:0] modem_in;
    int n_errors, comparisons;
    dcomm_regs dcomm_regs_i (.*);
    dcomm_line_model dcomm_line_model_i (.*);
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    function automatic logic [31:0] exp_free(input logic [7:0] f);
        return (f >= 8'h09) ? {24'h0, f} : 32'h0;
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wreg(input logic [3:0] i, input logic [31:0] d, input logic [1:0] er);
        logic aw_hit, w_hit, hit;
        logic [1:0] r;
        int n;
        hit = 1'b0;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!hit && n < 100) begin
            @(negedge aclk);
            aw_hit = s_axi_awvalid && s_axi_awready;
            w_hit = s_axi_wvalid && s_axi_wready;
            hit = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            s_axi_awvalid <= s_axi_awvalid & ~aw_hit;
            s_axi_wvalid <= s_axi_wvalid & ~w_hit;
            s_axi_bready <= ~hit;
            n++;
        end
        if (!hit) begin
            n_errors++;
            wrap_up();
        end else begin
            cmp({30'h0, r}, {30'h0, er});
        end
    endtask
    task automatic rreg(input logic [3:0] i, input logic [31:0] exp, input logic [1:0] er);
        logic ar_hit, hit;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        hit = 1'b0;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!hit && n < 100) begin
            @(negedge aclk);
            ar_hit = s_axi_arvalid && s_axi_arready;
            hit = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            s_axi_arvalid <= s_axi_arvalid & ~ar_hit;
            s_axi_rready <= ~hit;
            n++;
        end
        if (!hit) begin
            n_errors++;
            wrap_up();
        end else begin
            cmp(d, exp);
            cmp({30'h0, r}, {30'h0, er});
        end
    endtask
    task automatic ev_pulse(input logic [7:0] v);
        @(posedge aclk);
        event_pulse <= v;
        @(posedge aclk);
        event_pulse <= 8'h00;
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, event_pulse, cb_type, cb_mode} = '0;
        {switch_link_mode, inbound_has_data, inbound_has_ctrl, half_duplex, data_output} = '0;
        {cb_valid, dial_done, modem_in} = '0;
        s_axi_wstrb = 4'hf;
        outbound_free = 8'h00;
        fv = '{8'h08, 8'h09, 8'hff, 8'h40};
        seed = 32'h59aa;
        n_errors = 0;
        comparisons = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rreg(REG_MODEM_OUT, 32'h0, AXI_OKAY);
        rreg(REG_MASK, 32'h0, AXI_OKAY);
        rreg(REG_PROTOCOL, {24'h0, PROTO_ASYNC}, AXI_OKAY);
        rreg(REG_CONNECT, {24'h0, CONN_DISC}, AXI_OKAY);
        $display("test defaults done");
        wreg(REG_MODEM_OUT, 32'h100, AXI_SLVERR);
        rreg(REG_MODEM_OUT, 32'h0, AXI_OKAY);
        wreg(REG_CONNECT, 32'h7, AXI_SLVERR);
        rreg(REG_CONNECT, {24'h0, CONN_DISC}, AXI_OKAY);
        wreg(REG_PROTOCOL, 32'h3, AXI_SLVERR);
        rreg(REG_ERROR, {16'h0, ERR_ILLEGAL}, AXI_OKAY);
        wreg(REG_MODEM_IN, 32'h1, AXI_SLVERR);
        rreg(4'hf, 32'h0, AXI_SLVERR);
        $display("test refusals done");
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            modem_in <= seed[12:8];
            {inbound_has_ctrl, inbound_has_data} <= i[1:0];
            outbound_free <= fv[i];
            wreg(REG_MODEM_OUT, {24'h0, seed[7:0]}, AXI_OKAY);
            rreg(REG_MODEM_OUT, {24'h0, seed[7:0]}, AXI_OKAY);
            cmp({24'h0, modem_out}, {24'h0, seed[7:0]});
            wreg(REG_MASK, {24'h0, seed[23:16]}, AXI_OKAY);
            rreg(REG_MASK, {24'h0, seed[23:16]}, AXI_OKAY);
            rreg(REG_MODEM_IN, {27'h0, seed[12:8]}, AXI_OKAY);
            rreg(REG_INBOUND, {30'h0, i[1:0]}, AXI_OKAY);
            rreg(REG_FREE, exp_free(fv[i]), AXI_OKAY);
            ev_pulse(seed[31:24] | 8'h01);
            rreg(REG_CAUSE, {24'h0, seed[31:24] | 8'h01}, AXI_OKAY);
            rreg(REG_CAUSE, 32'h0, AXI_OKAY);
        end
        wreg(REG_MODEM_OUT, 32'h0, AXI_OKAY);
        $display("test random registers done");
        wreg(REG_BREAK, {24'h0, seed[7:0]}, AXI_OKAY);
        rreg(REG_BREAK, 32'h1, AXI_OKAY);
        repeat (20) @(posedge aclk);
        rreg(REG_BREAK, 32'h0, AXI_OKAY);
        wreg(REG_CONNECT, 32'h1, AXI_OKAY);
        rreg(REG_CONNECT, {24'h0, CONN_TRY}, AXI_OKAY);
        repeat (30) @(posedge aclk);
        rreg(REG_CONNECT, {24'h0, CONN_UP}, AXI_OKAY);
        wreg(REG_CONNECT, 32'h0, AXI_OKAY);
        rreg(REG_CONNECT, {24'h0, CONN_DISC}, AXI_OKAY);
        wreg(REG_CONNECT, 32'h2, AXI_OKAY);
        rreg(REG_CONNECT, {24'h0, CONN_DIAL}, AXI_OKAY);
        @(posedge aclk);
        dial_done <= 1'b1;
        @(posedge aclk);
        dial_done <= 1'b0;
        rreg(REG_CONNECT, {24'h0, CONN_TRY}, AXI_OKAY);
        cmp({30'h0, modem_out[1:0]}, 32'h3);
        wreg(REG_CONNECT, 32'h0, AXI_OKAY);
        $display("test break and connection done");
        @(posedge aclk);
        {cb_valid, cb_type, cb_mode} <= {1'b1, CB_ERR, 8'h03};
        @(posedge aclk);
        cb_valid <= 1'b0;
        rreg(REG_CB_TYPE, {24'h0, CB_ERR}, AXI_OKAY);
        rreg(REG_CB_MODE, 32'h3, AXI_OKAY);
        half_duplex <= 1'b1;
        wreg(REG_MODEM_OUT, 32'h3, AXI_OKAY);
        wreg(REG_INBOUND, 32'h0, AXI_OKAY);
        rreg(REG_MODEM_OUT, 32'h2, AXI_OKAY);
        wreg(REG_MODEM_OUT, 32'h3, AXI_OKAY);
        rreg(REG_MODEM_OUT, 32'h2, AXI_OKAY);
        @(posedge aclk);
        data_output <= 1'b1;
        @(posedge aclk);
        data_output <= 1'b0;
        rreg(REG_MODEM_OUT, 32'h3, AXI_OKAY);
        half_duplex <= 1'b0;
        $display("test control block and turnaround done");
        wreg(REG_PROTOCOL, {24'h0, PROTO_LINK}, AXI_OKAY);
        rreg(REG_PROTOCOL, {24'h0, PROTO_ASYNC}, AXI_OKAY);
        wreg(REG_IDENT, 32'h1, AXI_OKAY);
        rreg(REG_PROTOCOL, {24'h0, PROTO_LINK}, AXI_OKAY);
        rreg(REG_MODEM_OUT, 32'h0, AXI_OKAY);
        cmp({31'h0, link_mode}, 32'h1);
        ev_pulse(8'hff);
        rreg(REG_CAUSE, 32'h3f, AXI_OKAY);
        wreg(REG_INBOUND, 32'h0, AXI_OKAY);
        wreg(REG_BREAK, 32'h5, AXI_OKAY);
        $display("test data link done");
        switch_link_mode <= 1'b1;
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rreg(REG_PROTOCOL, {24'h0, PROTO_LINK}, AXI_OKAY);
        rreg(REG_MODEM_OUT, 32'h0, AXI_OKAY);
        rreg(REG_BREAK, 32'h0, AXI_OKAY);
        $display("test second reset done");
        wrap_up();
    end
endmodule
bind dcomm_regs dcomm_regs_properties dcomm_regs_properties_i (.*);
